// ---- design/pwmoc_top.v ----
// pwm output conditioning: dead time, masking, brake, polarity and pin select
`timescale 1ns/1ns
`default_nettype none
`include "pwmoc_defines.vh"

// channel path, one register stage in the pair block and one at the pin:
//   generator -> dead time -> force -> brake -> polarity -> pin mux -> pin
// every generator edge reaches the pin two clocks later on every channel,
// so a pair with dead time off keeps the same timing as one with it on
// apart from the inserted hold itself
//
// register bus:
//   writes land at the rising edge where the write strobe is high
//   reads are captured into the read register the same way
//   the read register holds its value until the next read strobe
//   unused bits read back as zero on every register
//   unmapped addresses read as zero and ignore writes
//
// dead-time registers:
//   the enable byte and the count byte only take a write in a cycle
//   where the unlock input is high; without it the write just vanishes
//   no error is raised, so firmware has to read back if it cares
//   the nine-bit count is enable bit 4 on top of the count byte
//   the hold is count+1 clocks from the edge that the pair block sees
//   a count change mid-run only acts from the next rising edge; a hold in flight keeps its count;
//   software is expected to change it only while stopped
//
// dead-time pair behaviour:
//   each pair has its own rising-edge hold for both of its signals
//   the hold only acts when the pair enable is set and the pair
//   runs complementary; otherwise both signals pass with one clock
//   a falling edge is never delayed, so the hold only ever widens
//   the gap in which both signals of a pair are low
//   the two counters of a pair are loaded independently
//
// force stage:
//   a set force enable bit replaces the channel by its force value bit
//   this happens after dead time, so a forced level is not delayed
//
// brake:
//   the edge detector compares the pin with its value one clock back
//   the edge select bit chooses falling (0) or rising (1)
//   an edge only counts while the brake input enable is high
//   an event sets the flag, starts the override and pulses run_clear
//   the override keeps all six channels at the brake data bits
//   clearing the flag does not end the override; only a run bit
//   seen high again, outside the run_clear pulse, ends it
//   a run bit still high right after the pulse would end the override
//   one clock later; the generator is expected to drop it first
//   a flag set by software alone does not start the override
//   the flag is written with its own bit: 0 clears, 1 sets
//   a hardware set in the same cycle as a software clear wins
//
// polarity and pins:
//   polarity is the last stage before the pin mux, so it also inverts forced and
//   brake levels at the pin
//   channels 1, 2, 3 and 5 share their pin with plain port data;
//   channels 0 and 4 always drive the pwm path
//   port data bits 0 and 4 are ignored for that reason
//
// outputs:
//   pin_out, run_clear, brake_flag_out and sfr_rdata are flip-flops
//   brake_flag_out lags the flag in the brake byte by one clock
//
// limitations:
//   inputs are taken as synchronous to the clock; an asynchronous
//   brake source must be synchronised before it reaches this block
//   the brake pin history resets low, so a pin that idles high shows
//   a rising edge right after reset; keep the enable low until then
module pwmoc_top #(
  parameter NCH = 6
) (
  input  wire           clock,
  input  wire           rst,
  input  wire [7:0]     sfr_addr,
  input  wire [7:0]     sfr_wdata,
  input  wire           sfr_wr,
  input  wire           sfr_rd,
  output reg  [7:0]     sfr_rdata,
  input  wire           timed_access,
  input  wire [NCH-1:0] generator_out,
  input  wire [2:0]     pair_complementary,
  input  wire           generator_run_bit,
  input  wire           brake_input_on,
  input  wire           brake_input_pin,
  input  wire [NCH-1:0] port_out,
  output reg  [NCH-1:0] pin_out,
  output reg            run_clear,
  output reg            brake_flag_out
);

  // registers
  reg [7:0] alt_pin_ff;
  reg [7:0] polarity_ff;
  reg [7:0] brake_reg_ff;
  reg [7:0] dt_enable_ff;
  reg [7:0] dt_count_ff;
  reg [7:0] force_en_ff;
  reg [7:0] force_val_ff;
  reg       brake_hold_ff;
  reg       brake_pin_last_ff;
  reg [7:0] nxt_rdata;

  wire wr_alt   = sfr_wr && sfr_addr == `PWMOC_ADDR_ALT_PIN;
  wire wr_pol   = sfr_wr && sfr_addr == `PWMOC_ADDR_POLARITY;
  wire wr_brk   = sfr_wr && sfr_addr == `PWMOC_ADDR_BRAKE;
  wire wr_dten  = sfr_wr && sfr_addr == `PWMOC_ADDR_DT_ENABLE && timed_access;
  wire wr_dtcnt = sfr_wr && sfr_addr == `PWMOC_ADDR_DT_COUNT && timed_access;
  wire wr_fen   = sfr_wr && sfr_addr == `PWMOC_ADDR_FORCE_EN;
  wire wr_fval  = sfr_wr && sfr_addr == `PWMOC_ADDR_FORCE_VAL;

  // brake edge detection on the pin, direction chosen by software
  wire brake_edge_sel = brake_reg_ff[`PWMOC_BIT_BRAKE_EDGE];
  wire rise_seen      = brake_input_pin && !brake_pin_last_ff;
  wire fall_seen      = !brake_input_pin && brake_pin_last_ff;
  wire brake_event    = brake_input_on &&
                        (brake_edge_sel ? rise_seen : fall_seen);

  // nine-bit dead-time count assembled from two registers
  wire [`PWMOC_DT_WIDTH-1:0] dt_count =
    {dt_enable_ff[`PWMOC_BIT_DT_CNT8], dt_count_ff};

  // brake pin history for the edge detector
  always @(posedge clock or posedge rst) begin
    if (rst)
      brake_pin_last_ff <= 1'b0;
    else
      brake_pin_last_ff <= brake_input_pin;
  end

  // pin select: only the four shared channels keep a bit
  always @(posedge clock or posedge rst) begin
    if (rst)
      alt_pin_ff <= `PWMOC_RST_BYTE;
    else if (wr_alt)
      alt_pin_ff <= sfr_wdata & `PWMOC_ALT_PIN_MASK;
  end

  // polarity: one bit per channel
  always @(posedge clock or posedge rst) begin
    if (rst)
      polarity_ff <= `PWMOC_RST_BYTE;
    else if (wr_pol)
      polarity_ff <= sfr_wdata & `PWMOC_CH_MASK;
  end

  // pair enables and count bit 8; the decode already needs the unlock
  always @(posedge clock or posedge rst) begin
    if (rst)
      dt_enable_ff <= `PWMOC_RST_BYTE;
    else if (wr_dten)
      dt_enable_ff <= sfr_wdata & `PWMOC_DT_EN_MASK;
  end

  // count low byte; a change mid-run is only loaded at the next rising edge
  always @(posedge clock or posedge rst) begin
    if (rst)
      dt_count_ff <= `PWMOC_RST_BYTE;
    else if (wr_dtcnt)
      dt_count_ff <= sfr_wdata;
  end

  // force enable per channel
  always @(posedge clock or posedge rst) begin
    if (rst)
      force_en_ff <= `PWMOC_RST_BYTE;
    else if (wr_fen)
      force_en_ff <= sfr_wdata & `PWMOC_CH_MASK;
  end

  // force value per channel
  always @(posedge clock or posedge rst) begin
    if (rst)
      force_val_ff <= `PWMOC_RST_BYTE;
    else if (wr_fval)
      force_val_ff <= sfr_wdata & `PWMOC_CH_MASK;
  end

  // brake byte: data and edge select from software, flag from both sides
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      brake_reg_ff <= `PWMOC_RST_BYTE;
    end else begin
      if (wr_brk)
        brake_reg_ff[6:0] <= sfr_wdata[6:0];
      // set wins over a same-cycle software clear
      if (brake_event)
        brake_reg_ff[`PWMOC_BIT_BRAKE_FLAG] <= 1'b1;
      else if (wr_brk)
        brake_reg_ff[`PWMOC_BIT_BRAKE_FLAG] <= sfr_wdata[`PWMOC_BIT_BRAKE_FLAG];
    end
  end

  // one-clock pulse that tells the generator to drop its run bit
  always @(posedge clock or posedge rst) begin
    if (rst)
      run_clear <= 1'b0;
    else
      run_clear <= brake_event;
  end

  // brake override stays on after the flag clears, until run is set again;
  // the pulse cycle is skipped so a stale run bit cannot end it at once
  always @(posedge clock or posedge rst) begin
    if (rst)
      brake_hold_ff <= 1'b0;
    else if (brake_event)
      brake_hold_ff <= 1'b1;
    else if (generator_run_bit && !run_clear)
      brake_hold_ff <= 1'b0;
  end

  // per-pair dead-time stage; enable ignored unless pair is complementary
  wire [NCH-1:0] dt_out;
  genvar p;
  generate
    for (p = 0; p < NCH/2; p = p + 1) begin : g_pair
      pwmoc_deadtime #(
        .CW (`PWMOC_DT_WIDTH)
      ) u_dt (
        .clock  (clock),
        .rst    (rst),
        .active (dt_enable_ff[p] && pair_complementary[p]),
        .count  (dt_count),
        .in_a   (generator_out[2*p]),
        .in_b   (generator_out[2*p+1]),
        .out_a  (dt_out[2*p]),
        .out_b  (dt_out[2*p+1])
      );
    end
  endgenerate

  // mask, brake, polarity in that order after dead time
  reg [NCH-1:0] stage_mask;
  reg [NCH-1:0] stage_brake;
  reg [NCH-1:0] stage_pol;
  reg [NCH-1:0] nxt_pin;
  integer i;
  always @* begin
    stage_mask  = {NCH{1'b0}};
    stage_brake = {NCH{1'b0}};
    stage_pol   = {NCH{1'b0}};
    nxt_pin     = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      stage_mask[i]  = force_en_ff[i] ? force_val_ff[i] : dt_out[i];
      stage_brake[i] = brake_hold_ff ? brake_reg_ff[i] : stage_mask[i];
      stage_pol[i]   = stage_pol_bit(stage_brake[i], polarity_ff[i]);
      nxt_pin[i]     = stage_pol[i];
    end
    // only channels with an alternate-select bit get a pin mux here
    nxt_pin[1] = alt_pin_ff[1] ? stage_pol[1] : port_out[1];
    nxt_pin[2] = alt_pin_ff[2] ? stage_pol[2] : port_out[2];
    nxt_pin[3] = alt_pin_ff[3] ? stage_pol[3] : port_out[3];
    nxt_pin[5] = alt_pin_ff[5] ? stage_pol[5] : port_out[5];
  end

  function stage_pol_bit;
    input d;
    input inv;
    begin
      stage_pol_bit = d ^ inv;
    end
  endfunction

  // registered pins; adds one clock of latency, uniform for every channel
  always @(posedge clock or posedge rst) begin
    if (rst)
      pin_out <= {NCH{1'b0}};
    else
      pin_out <= nxt_pin;
  end

  // flag copy for the outside, one clock behind the brake byte
  always @(posedge clock or posedge rst) begin
    if (rst)
      brake_flag_out <= 1'b0;
    else
      brake_flag_out <= brake_reg_ff[`PWMOC_BIT_BRAKE_FLAG];
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (sfr_addr)
      `PWMOC_ADDR_ALT_PIN:   nxt_rdata = alt_pin_ff;
      `PWMOC_ADDR_POLARITY:  nxt_rdata = polarity_ff;
      `PWMOC_ADDR_BRAKE:     nxt_rdata = brake_reg_ff;
      `PWMOC_ADDR_DT_ENABLE: nxt_rdata = dt_enable_ff;
      `PWMOC_ADDR_DT_COUNT:  nxt_rdata = dt_count_ff;
      `PWMOC_ADDR_FORCE_EN:  nxt_rdata = force_en_ff;
      `PWMOC_ADDR_FORCE_VAL: nxt_rdata = force_val_ff;
      default:               nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= nxt_rdata;
  end

endmodule
`default_nettype wire

// ---- design/pwmoc_defines.vh ----
// register offsets, field positions, reset values and the dead-time count width for pwm output conditioning
`ifndef PWMOC_DEFINES_VH
`define PWMOC_DEFINES_VH

`define PWMOC_ADDR_ALT_PIN    8'hc6
`define PWMOC_ADDR_POLARITY   8'hd6
`define PWMOC_ADDR_BRAKE      8'hd7
`define PWMOC_ADDR_DT_ENABLE  8'hf9
`define PWMOC_ADDR_DT_COUNT   8'hfa
`define PWMOC_ADDR_FORCE_EN   8'hfb
`define PWMOC_ADDR_FORCE_VAL  8'hfc

`define PWMOC_RST_BYTE        8'h00

// implemented bit masks
`define PWMOC_ALT_PIN_MASK    8'h2e
`define PWMOC_CH_MASK         8'h3f
`define PWMOC_DT_EN_MASK      8'h17

// field positions
`define PWMOC_BIT_BRAKE_FLAG  7
`define PWMOC_BIT_BRAKE_EDGE  6
`define PWMOC_BIT_DT_CNT8     4

`define PWMOC_DT_WIDTH        9

`endif

// ---- design/pwmoc_deadtime.v ----
// one complementary pair: rising-edge delay on both signals of the pair
`timescale 1ns/1ns
`default_nettype none
module pwmoc_deadtime #(
  parameter CW = 9
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          active,
  input  wire [CW-1:0] count,
  input  wire          in_a,
  input  wire          in_b,
  output reg           out_a,
  output reg           out_b
);

  reg  [CW:0] cnt_a_ff;
  reg  [CW:0] cnt_b_ff;
  reg         last_a_ff;
  reg         last_b_ff;
  wire [CW:0] load = {1'b0, count};

  // while active, each rising edge holds the output low for count+1 clocks before following
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_a_ff  <= {(CW+1){1'b0}};
      cnt_b_ff  <= {(CW+1){1'b0}};
      last_a_ff <= 1'b0;
      last_b_ff <= 1'b0;
      out_a     <= 1'b0;
      out_b     <= 1'b0;
    end else begin
      last_a_ff <= in_a;
      last_b_ff <= in_b;
      if (!active) begin
        cnt_a_ff <= {(CW+1){1'b0}};
        cnt_b_ff <= {(CW+1){1'b0}};
      end else begin
        if (in_a && !last_a_ff)
          cnt_a_ff <= load;
        else if (cnt_a_ff != {(CW+1){1'b0}})
          cnt_a_ff <= cnt_a_ff - 1'b1;
        if (in_b && !last_b_ff)
          cnt_b_ff <= load;
        else if (cnt_b_ff != {(CW+1){1'b0}})
          cnt_b_ff <= cnt_b_ff - 1'b1;
      end
      // the edge cycle itself plus count cycles of hold give count+1 periods
      out_a <= active ? (in_a && last_a_ff && cnt_a_ff == {(CW+1){1'b0}}) : in_a;
      out_b <= active ? (in_b && last_b_ff && cnt_b_ff == {(CW+1){1'b0}}) : in_b;
    end
  end

endmodule
`default_nettype wire

// ---- verif/pwmoc_top_assertions.sv ----
// port-level checks on the brake and flag behaviour
`timescale 1ns/1ns
`default_nettype none
module pwmoc_top_assertions #(
  parameter NCH = 6
) (
  input wire logic           clock,
  input wire logic           rst,
  input wire logic [7:0]     sfr_addr,
  input wire logic [7:0]     sfr_wdata,
  input wire logic           sfr_wr,
  input wire logic           sfr_rd,
  input wire logic [7:0]     sfr_rdata,
  input wire logic           generator_run_bit,
  input wire logic           brake_input_on,
  input wire logic           brake_input_pin,
  input wire logic [NCH-1:0] pin_out,
  input wire logic           run_clear,
  input wire logic           brake_flag_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // software write to the brake byte
  wire d7_wr = sfr_wr && sfr_addr == 8'hd7;
  // trip and release steps
  sequence s_trip; run_clear ##1 brake_flag_out; endsequence
  sequence s_release; brake_flag_out ##1 !brake_flag_out; endsequence
  property p_trip_flag; run_clear |=> brake_flag_out; endproperty
  property p_trip_cause;
    run_clear |-> $past(brake_input_on) && $past(brake_input_pin) != $past(brake_input_pin, 2);
  endproperty
  property p_pulse; run_clear |=> !run_clear; endproperty
  property p_sticky; $fell(brake_flag_out) |-> $past(d7_wr && !sfr_wdata[7], 2); endproperty
  property p_rose;
    $rose(brake_flag_out) |-> $past(run_clear) || $past(d7_wr && sfr_wdata[7], 2);
  endproperty
  property p_hold; s_trip |=> $stable(pin_out) [*4]; endproperty
  property p_keep; s_release ##0 !generator_run_bit |=> $stable(pin_out) [*2]; endproperty
  property p_flag_rd; sfr_rd && sfr_addr == 8'hd7 |=> sfr_rdata[7] == brake_flag_out; endproperty
  a_trip_flag: assert property (p_trip_flag)
    else $error("trip left flag clear");
  a_trip_cause: assert property (p_trip_cause)
    else $error("run clear without enabled pin edge");
  a_pulse: assert property (p_pulse)
    else $error("run clear longer than one cycle");
  a_sticky: assert property (p_sticky)
    else $error("flag fell without software clear");
  a_rose: assert property (p_rose)
    else $error("flag rose without cause");
  a_hold: assert property (p_hold)
    else $error("pins moved under brake");
  a_keep: assert property (p_keep)
    else $error("pins released before run bit");
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag readback differs");
endmodule
bind pwmoc_top pwmoc_top_assertions #(.NCH(NCH)) pwmoc_top_assertions_inst (
  .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .generator_run_bit(generator_run_bit), .brake_input_on(brake_input_on),
  .brake_input_pin(brake_input_pin), .pin_out(pin_out), .run_clear(run_clear),
  .brake_flag_out(brake_flag_out));
`default_nettype wire

// ---- verif/pwmoc_stage.sv ----
// power stage model: its fault detector drives the brake pin
`timescale 1ns/1ns
`default_nettype none
module pwmoc_stage (
  input  wire logic trip,
  input  wire logic rising,
  output logic      fault_pin
);
  // idles at the opposite level so a trip is one clean edge
  assign fault_pin = rising ? trip : ~trip;
endmodule
`default_nettype wire

// ---- verif/pwmoc_top_bench.sv ----
// random and corner tests of pwm output conditioning
`timescale 1ns/1ns
`default_nettype none
module pwmoc_top_bench;
  localparam logic [7:0] ADR [7] = '{8'hc6, 8'hd6, 8'hd7, 8'hf9, 8'hfa, 8'hfb, 8'hfc};
  localparam logic [7:0] MSK [7] = '{8'h2e, 8'h3f, 8'h7f, 8'h17, 8'hff, 8'h3f, 8'h3f};
  localparam logic [7:0] DTE [5] = '{8'h01, 8'h01, 8'h11, 8'h02, 8'h01};
  logic       clock, rst, sfr_wr, sfr_rd, unlock, run, bon, trip, rising;
  logic [7:0] sfr_addr, sfr_wdata, r;
  logic [5:0] gen, port, alt, pol, fe, fv, bd;
  logic [2:0] comp;
  wire  [7:0] rdata;
  wire  [5:0] pin;
  wire        run_clear, flag, fpin;
  integer     n_fail, cmp_count, seed, i, k, n_rc, t0, d0;
  pwmoc_top pwmoc_top_inst (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(rdata),
    .timed_access(unlock), .generator_out(gen), .pair_complementary(comp),
    .generator_run_bit(run), .brake_input_on(bon), .brake_input_pin(fpin),
    .port_out(port), .pin_out(pin), .run_clear(run_clear), .brake_flag_out(flag));
  pwmoc_stage pwmoc_stage_inst (.trip(trip), .rising(rising), .fault_pin(fpin));
  // 4 ns clock
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // run clear pulses are short, so count them as they pass
  always @(posedge clock) if (run_clear === 1'b1) n_rc++;
  task automatic cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask
  task automatic cmp(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobes rise and fall on falling edges, one idle cycle between accesses
  task automatic wr(input [7:0] a, input [7:0] d, input t);
    @(negedge clock);
    {sfr_addr, sfr_wdata, unlock, sfr_wr} = {a, d, t, 1'b1};
    @(negedge clock);
    {unlock, sfr_wr} = 2'b00;
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    @(negedge clock);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge clock);
    sfr_rd = 0;
    cmp({8'h00, rdata}, {8'h00, e});
  endtask
  // pin level: polarity after the chosen source, port data where alt is off
  function automatic [15:0] expf(input [5:0] v);
    logic [5:0] s;
    s = alt | 6'h11;
    expf = {10'h000, ((v ^ pol) & s) | (port & ~s)};
  endfunction
  // cycles from generator rise to pin rise on channel 0
  task automatic dly(output integer d);
    gen = 6'h02;
    cyc(4);
    gen = 6'h01;
    d = 0;
    while (pin[0] !== 1'b1 && d < 700) begin
      cyc(1);
      d++;
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog well beyond the longest dead-time sweep
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
  initial begin
    seed = 32'h9f67b71d;
    {n_fail, cmp_count, n_rc} = 0;
    {sfr_wr, sfr_rd, unlock, run, bon, trip, rising, sfr_addr, sfr_wdata, gen, port, comp} = 0;
    rst = 1;
    cyc(10);
    rst = 0;
    for (i = 0; i < 7; i++) rd(ADR[i], 8'h00);
    for (i = 0; i < 7; i++) begin
      r = $random(seed);
      if (i == 2) r[7] = 1'b0;
      wr(ADR[i], r, 1);
      rd(ADR[i], r & MSK[i]);
    end
    wr(8'hf9, 8'h00, 1);
    wr(8'hfa, 8'h00, 1);
    wr(8'hf9, 8'h17, 0);
    wr(8'hfa, 8'hff, 0);
    rd(8'hf9, 8'h00);
    rd(8'hfa, 8'h00);
    rd(8'hc7, 8'h00);
    for (i = 0; i < 30; i++) begin
      {alt, pol, fe} = $random(seed);
      {fv, gen, port} = $random(seed);
      alt &= 6'h2e;
      wr(8'hc6, {2'b00, alt}, 0);
      wr(8'hd6, {2'b00, pol}, 0);
      wr(8'hfb, {2'b00, fe}, 0);
      wr(8'hfc, {2'b00, fv}, 0);
      cyc(1);
      cmp({10'h000, pin}, expf((gen & ~fe) | (fv & fe)));
    end
    wr(8'hfb, 8'h00, 0);
    wr(8'hd6, 8'h00, 0);
    comp = 3'b001;
    dly(d0);
    for (k = 0; k < 5; k++) begin
      r = k == 4 ? $random(seed) : (k == 2 ? 8'h00 : 8'h05);
      comp = {2'b00, k != 1};
      wr(8'hf9, DTE[k], 1);
      wr(8'hfa, r, 1);
      dly(t0);
      cmp(16'(t0 - d0), (DTE[k][0] & comp[0]) ? {7'h00, DTE[k][4], r} + 16'h1 : 16'h0);
    end
    {fe, fv} = {6'h3f, 6'h15};
    wr(8'hfb, 8'h3f, 0);
    wr(8'hfc, 8'h15, 0);
    for (k = 0; k < 2; k++) begin
      {bd, pol} = $random(seed);
      {alt, rising, run, bon, n_rc} = {6'h2e, k[0], 2'b00, 32'h0};
      wr(8'hc6, {2'b00, alt}, 0);
      wr(8'hd6, {2'b00, pol}, 0);
      wr(8'hd7, {1'b0, k[0], bd}, 0);
      trip = 1;
      cyc(4);
      cmp({15'h0, flag}, 16'h0);
      {trip, bon} = 2'b01;
      cyc(3);
      trip = 1;
      cyc(4);
      cmp(16'(n_rc), 16'h1);
      cmp({10'h000, pin}, expf(bd));
      gen = $random(seed);
      rd(8'hd7, {1'b1, k[0], bd});
      cmp({10'h000, pin}, expf(bd));
      wr(8'hd7, {1'b0, k[0], bd}, 0);
      cyc(3);
      cmp({15'h0, flag}, 16'h0);
      cmp({10'h000, pin}, expf(bd));
      run = 1;
      cyc(4);
      cmp({10'h000, pin}, expf(fv));
      trip = 0;
      cyc(4);
      cmp({15'h0, flag}, 16'h0);
    end
    close_out;
  end
endmodule
`default_nettype wire
